/* rtl/ssl_clk_div.sv */
// divider: one-cycle enable pulse every DIV cycles of the fast source clock
// assumes clk_i is the fast source clock
`timescale 1ns/100ps
module ssl_clk_div #(
    parameter int DIV = 4
) (
    input  wire logic clk_i,     // fast source clock
    input  wire logic reset_i,   // async reset, high
    output logic      half_o,    // half rate enable
    output logic      bus_en_o   // bus rate enable
);
    typedef struct packed {
        logic [7:0] cnt;
    } ssl_div_t;

    ssl_div_t s_q;
    ssl_div_t s_d;

    initial begin
        if (DIV < 2 || DIV > 256 || DIV % 2 != 0) begin
            $error("ssl_clk_div: DIV must be even and 2..256");
        end
    end

    always_comb begin
        s_d = s_q;
        if (s_q.cnt == 8'(DIV - 1)) begin
            s_d.cnt = 8'h00;
        end else begin
            s_d.cnt = s_q.cnt + 8'h01;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // bit zero divides by two, terminal count divides by DIV
    assign half_o   = s_q.cnt[0];
    assign bus_en_o = (s_q.cnt == 8'(DIV - 1));
endmodule

/* rtl/ssl_ctrl.sv */
// system state controller: bus clock enables, wait and stop sequencing,
// break flag protection and the three user registers
// assumes a cpu that reports wait/stop/break events on bus-rate cycles
`timescale 1ns/100ps
`include "ssl_map.svh"

////////////////////////////////////////////////////////////////////////////////
module ssl_ctrl
    import ssl_pkg::*;
#(
    parameter int NUM_IRQ      = 24,
    parameter int RECOVERY_CYC = `SSL_STOP_RECOVERY_CYC
) (
    input  wire logic               clk_i,              // fast source clock
    input  wire logic               reset_i,            // async reset, high
    input  wire logic               por_i,              // power-on reset seen
    input  wire logic               pin_reset_i,        // reset from pin
    input  wire logic               wdog_reset_i,       // watchdog timeout
    input  wire logic               wait_exec_i,        // cpu executes wait
    input  wire logic               stop_exec_i,        // cpu executes stop
    input  wire logic               break_i,            // break interrupt
    input  wire logic               emulation_i,        // emulation mode
    input  wire logic [NUM_IRQ-1:0] irq_i,              // interrupt requests
    input  wire logic [NUM_IRQ-1:0] irq_en_i,           // interrupt enables
    input  wire logic               irq_rst_sel_i,      // config word two: pin funcs
    input  wire logic               watchdog_disable_i, // config bit
    input  wire logic               flag_clr_req_i,     // module asks to clear a flag
    input  wire logic               step_two_i,         // second step of two-step clear
    input  wire logic [15:0]        addr_i,             // register address
    input  wire logic [7:0]         wdata_i,            // write data
    input  wire logic               wr_i,               // write strobe
    input  wire logic               rd_i,               // read strobe
    output logic [7:0]              rdata_o,            // read data
    output logic                    half_clk_o,         // half source clock
    output logic                    bus_en_o,           // bus clock enable
    output logic                    cpu_clk_en_o,       // cpu clock enable
    output logic                    periph_clk_en_o,    // peripheral clock enable
    output logic                    clr_imask_o,        // clear cpu interrupt mask
    output logic                    stack_o,            // begin interrupt stacking
    output logic                    irq_pending_o,      // any enabled request
    output logic [4:0]              irq_vec_o,          // winning source index
    output logic                    swi_vec_o,          // force swi vector
    output logic                    flag_clr_ok_o,      // flag clear allowed
    output logic                    pin_funcs_o,        // pins take reset/irq
    output logic                    watchdog_run_o      // watchdog counting
);
    typedef struct packed {
        ssl_state_t  st;
        logic [15:0] cnt;
        logic [7:0]  brk_status;
        logic [7:0]  rst_source;
        logic [7:0]  brk_ctl;
        logic        clr_imask;
        logic        stack;
        logic        software_interrupt_vector;
        logic        in_break;
        logic [7:0]  rdata;
        logic        pin_funcs;
        logic [4:0]  vec;
    } ssl_regs_t;

    ssl_regs_t  r_q;
    ssl_regs_t  r_d;
    logic       bus_en;
    logic       wake;
    logic       any_irq;
    logic [4:0] win;

    initial begin
        if (NUM_IRQ < 1 || NUM_IRQ > 24) begin
            $error("ssl_ctrl: NUM_IRQ must be 1..24");
        end
        if (RECOVERY_CYC < 1 || RECOVERY_CYC > 65535) begin
            $error("ssl_ctrl: RECOVERY_CYC must be 1..65535");
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus clock runs at a quarter of the fast source clock
    ssl_clk_div #(
        .DIV (`SSL_BUS_DIV)
    ) u_div (
        .clk_i    (clk_i),
        .reset_i  (reset_i),
        .half_o   (half_clk_o),
        .bus_en_o (bus_en)
    );

    ////////////////////////////////////////////////////////////////////////////
    // fixed priority: lowest index wins
    always_comb begin
        any_irq = 1'b0;
        win     = 5'h00;
        for (int i = NUM_IRQ - 1; i >= 0; i--) begin
            if (irq_i[i] && irq_en_i[i]) begin
                any_irq = 1'b1;
                win     = 5'(i);
            end
        end
    end

    assign wake = any_irq || pin_reset_i || wdog_reset_i || (break_i && emulation_i);

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        r_d           = r_q;
        r_d.clr_imask = 1'b0;
        r_d.stack     = 1'b0;
        r_d.software_interrupt_vector       = 1'b0;
        if (irq_rst_sel_i) begin
            r_d.pin_funcs = 1'b1;
        end
        if (bus_en) begin
            r_d.vec = win;
            if (break_i) begin
                r_d.in_break = 1'b1;
                r_d.software_interrupt_vector      = 1'b1;
            end
            case (r_q.st)
                SSL_RUN: begin
                    if (wait_exec_i) begin
                        r_d.st        = SSL_WAIT;
                        r_d.clr_imask = 1'b1;
                    end else if (stop_exec_i) begin
                        r_d.st        = SSL_STOP;
                        r_d.clr_imask = 1'b1;
                        r_d.cnt       = 16'h0000;
                    end
                end
                SSL_WAIT: begin
                    if (break_i) begin
                        r_d.brk_status[`SSL_BIT_BREAK_WAIT] = 1'b1;
                    end
                    if (wake) begin
                        r_d.st = SSL_STACK;
                    end
                end
                SSL_STOP: begin
                    r_d.cnt = 16'h0000;
                    if (break_i) begin
                        r_d.brk_status[`SSL_BIT_BREAK_WAIT] = 1'b1;
                    end
                    if (any_irq || break_i) begin
                        r_d.st = SSL_RECOVER;
                    end
                end
                SSL_RECOVER: begin
                    if (r_q.cnt == 16'(RECOVERY_CYC - 1)) begin
                        r_d.st  = SSL_STACK;
                        r_d.cnt = 16'h0000;
                    end else begin
                        r_d.cnt = r_q.cnt + 16'h0001;
                    end
                end
                SSL_STACK: begin
                    r_d.stack = 1'b1;
                    r_d.st    = SSL_RUN;
                end
                default: begin
                    r_d.st = SSL_RUN;
                end
            endcase
        end
        // software writes; break-during-wait clears by writing zero, set wins
        if (wr_i) begin
            case (addr_i)
                `SSL_ADDR_BREAK_STATUS: begin
                    if (!wdata_i[`SSL_BIT_BREAK_WAIT] &&
                        !(bus_en && break_i && r_q.st inside {SSL_WAIT, SSL_STOP})) begin
                        r_d.brk_status[`SSL_BIT_BREAK_WAIT] = 1'b0;
                    end
                    if (!(bus_en && break_i)) begin
                        r_d.in_break = 1'b0;
                    end
                end
                `SSL_ADDR_BREAK_FLAG_CTL: begin
                    r_d.brk_ctl[`SSL_BIT_FLAG_CLR_EN] = wdata_i[`SSL_BIT_FLAG_CLR_EN];
                end
                default: begin
                end
            endcase
        end
        if (rd_i) begin
            case (addr_i)
                `SSL_ADDR_BREAK_STATUS:   r_d.rdata = r_q.brk_status;
                `SSL_ADDR_RESET_SOURCE: begin
                    r_d.rdata      = r_q.rst_source;
                    r_d.rst_source = 8'h00;
                end
                `SSL_ADDR_BREAK_FLAG_CTL: r_d.rdata = r_q.brk_ctl;
                default:                  r_d.rdata = 8'h00;
            endcase
        end
        // reset sources latched after the read clear so a new one wins
        if (por_i) begin
            r_d.rst_source[`SSL_RST_POR_BIT] = 1'b1;
        end
        if (pin_reset_i) begin
            r_d.rst_source[`SSL_RST_PIN_BIT] = 1'b1;
        end
        if (wdog_reset_i) begin
            r_d.rst_source[`SSL_RST_WDOG_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            r_q            <= '0;
            r_q.st         <= SSL_RUN;
            r_q.brk_status <= `SSL_BREAK_STATUS_RST;
            r_q.rst_source <= `SSL_RESET_SOURCE_RST;
            r_q.brk_ctl    <= `SSL_BREAK_FLAG_CTL_RST;
        end else begin
            r_q <= r_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign bus_en_o        = bus_en;
    assign cpu_clk_en_o    = bus_en && (r_q.st == SSL_RUN || r_q.st == SSL_STACK);
    assign periph_clk_en_o = bus_en && (r_q.st != SSL_STOP);
    assign watchdog_run_o  = !watchdog_disable_i && (r_q.st != SSL_STOP);
    // protection holds both steps of two-step clears while in break
    assign flag_clr_ok_o   = (flag_clr_req_i || step_two_i) &&
                             (!r_q.in_break || r_q.brk_ctl[`SSL_BIT_FLAG_CLR_EN]);
    assign clr_imask_o     = r_q.clr_imask;
    assign stack_o         = r_q.stack;
    assign swi_vec_o       = r_q.software_interrupt_vector;
    assign irq_pending_o   = any_irq;
    assign irq_vec_o       = r_q.vec;
    assign rdata_o         = r_q.rdata;
    assign pin_funcs_o     = r_q.pin_funcs;
endmodule

/* rtl/ssl_map.svh */
// register offsets, field positions, reset values and timing counts
// included only by the controller module ssl_ctrl
`ifndef SSL_MAP_SVH
`define SSL_MAP_SVH
`define SSL_ADDR_BREAK_STATUS   16'hFE00
`define SSL_ADDR_RESET_SOURCE   16'hFE01
`define SSL_ADDR_BREAK_FLAG_CTL 16'hFE03
`define SSL_BIT_BREAK_WAIT      1
`define SSL_BIT_FLAG_CLR_EN     7
`define SSL_RST_POR_BIT         7
`define SSL_RST_PIN_BIT         6
`define SSL_RST_WDOG_BIT        4
`define SSL_BREAK_STATUS_RST    8'h00
`define SSL_RESET_SOURCE_RST    8'h80
`define SSL_BREAK_FLAG_CTL_RST  8'h00
`define SSL_BUS_DIV             4
`define SSL_STOP_RECOVERY_CYC   4096
`endif

/* rtl/ssl_pkg.sv */
// types shared by the system state controller files
package ssl_pkg;
    typedef enum logic [2:0] {
        SSL_RUN     = 3'b000,
        SSL_WAIT    = 3'b001,
        SSL_STOP    = 3'b010,
        SSL_RECOVER = 3'b011,
        SSL_STACK   = 3'b100
    } ssl_state_t;
endpackage

/* sim/ssl_checker.sv */
// assertions on the ports of the system state controller
// assumes one clock domain, reset_i asynchronous and high
`timescale 1ns/100ps
module ssl_checker #(
    parameter int NUM_IRQ = 24
) (
    input wire logic               clk_i,
    input wire logic               reset_i,
    input wire logic               wait_exec_i,
    input wire logic               stop_exec_i,
    input wire logic               break_i,
    input wire logic [NUM_IRQ-1:0] irq_i,
    input wire logic [NUM_IRQ-1:0] irq_en_i,
    input wire logic               irq_rst_sel_i,
    input wire logic               watchdog_disable_i,
    input wire logic               rd_i,
    input wire logic [15:0]        addr_i,
    input wire logic [7:0]         rdata_o,
    input wire logic               half_clk_o,
    input wire logic               bus_en_o,
    input wire logic               cpu_clk_en_o,
    input wire logic               periph_clk_en_o,
    input wire logic               clr_imask_o,
    input wire logic               stack_o,
    input wire logic               irq_pending_o,
    input wire logic               swi_vec_o,
    input wire logic               pin_funcs_o,
    input wire logic               watchdog_run_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    AST_BUS_DIV: assert property (bus_en_o |=> !bus_en_o [*3] ##1 bus_en_o)
        else $error("bus enable not every fourth cycle");
    AST_HALF: assert property (1'b1 |=> half_clk_o != $past(half_clk_o))
        else $error("half clock not toggling");
    AST_PINS: assert property (!pin_funcs_o && !irq_rst_sel_i |=> !pin_funcs_o)
        else $error("pin functions taken without config");
    AST_PINS_HOLD: assert property (pin_funcs_o |=> pin_funcs_o)
        else $error("pin functions dropped");
    AST_IRQ: assert property (irq_pending_o == |(irq_i & irq_en_i))
        else $error("pending flag wrong");
    AST_IMASK: assert property (bus_en_o && (wait_exec_i || stop_exec_i) |=> clr_imask_o)
        else $error("mask not cleared");
    AST_CPU_HOLD: assert property (bus_en_o && (wait_exec_i || stop_exec_i)
        |=> !cpu_clk_en_o [*4])
        else $error("cpu clocked in low power");
    AST_PERIPH: assert property (bus_en_o && wait_exec_i |=> ##3 periph_clk_en_o)
        else $error("peripheral clock stopped in wait");
    AST_WAKE: assert property (bus_en_o && wait_exec_i ##4 bus_en_o && irq_pending_o
        && !break_i |=> ##4 stack_o)
        else $error("no stacking after wake");
    AST_WDOG: assert property (bus_en_o && wait_exec_i && !watchdog_disable_i
        |=> watchdog_run_o [*4])
        else $error("watchdog stopped in wait");
    AST_SWI: assert property (bus_en_o && break_i |=> swi_vec_o)
        else $error("break did not force vector");
    AST_UNMAPPED: assert property (rd_i && addr_i == 16'hFE02 |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    cover property (stack_o);
    cover property (swi_vec_o);
    cover property (clr_imask_o);
endmodule
bind ssl_ctrl ssl_checker #(.NUM_IRQ(NUM_IRQ)) u_chk (.*);

/* sim/ssl_cpu_model.sv */
// cpu side: issues wait, stop and break on bus enable cycles
// assumes bus_en_i is the controller's one-cycle bus enable
`timescale 1ns/100ps
module ssl_cpu_model (
    input  wire logic clk_i,   // fast source clock
    input  wire logic reset_i, // async reset, high
    input  wire logic bus_en_i, // bus enable
    output logic      wait_o,  // wait executed
    output logic      stop_o,  // stop executed
    output logic      brk_o    // break interrupt
);
    initial {wait_o, stop_o, brk_o} = 3'b000;
    // k: 1 wait, 2 stop, 3 break; d extra clocks of delay
    task issue(input int k, input int d);
        repeat (d) @(posedge clk_i);
        @(posedge clk_i);
        #10;
        while (bus_en_i !== 1'b1 || reset_i) begin
            @(posedge clk_i);
            #10;
        end
        wait_o = (k == 1);
        stop_o = (k == 2);
        brk_o  = (k == 3);
        @(posedge clk_i);
        #10;
        {wait_o, stop_o, brk_o} = 3'b000;
    endtask
endmodule

/* sim/testbench.sv */
// self-checking bench of the system state controller
// assumes the cpu model drives wait, stop and break
`timescale 1ns/100ps
module testbench;
    logic        clk_i, reset_i, por_i, pin_reset_i, wdog_reset_i, emulation_i;
    logic        irq_rst_sel_i, watchdog_disable_i, flag_clr_req_i, step_two_i;
    logic        wr_i, rd_i, wait_exec_i, stop_exec_i, break_i, half_clk_o, bus_en_o;
    logic        cpu_clk_en_o, periph_clk_en_o, clr_imask_o, stack_o, irq_pending_o;
    logic        swi_vec_o, flag_clr_ok_o, pin_funcs_o, watchdog_run_o;
    logic [23:0] irq_i, irq_en_i;
    logic [15:0] addr_i;
    logic [7:0]  wdata_i, rdata_o;
    logic [4:0]  irq_vec_o;
    int          failures, checks, seed, hn, d, lo;
    ssl_ctrl #(.RECOVERY_CYC(4)) uut (.*);
    ssl_cpu_model cpu (.clk_i(clk_i), .reset_i(reset_i), .bus_en_i(bus_en_o),
        .wait_o(wait_exec_i), .stop_o(stop_exec_i), .brk_o(break_i));
    initial begin
        clk_i = 0;
        forever #50 clk_i = ~clk_i;
    end
    ////////////////////////////////////////////////////////////////////////
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task acc(input logic w, input logic [15:0] a, input logic [7:0] v);
        @(posedge clk_i);
        #10;
        {wr_i, rd_i, addr_i, wdata_i} = {w, !w, a, v};
        @(posedge clk_i);
        #10;
        {wr_i, rd_i} = 2'b00;
        if (!w) chk("rdata", v, rdata_o);
    endtask
    task hunt(input logic s, input int lim);
        hn = 0;
        while (hn < lim && (s ? cpu_clk_en_o : stack_o) !== 1'b1) begin
            @(posedge clk_i);
            #10;
            hn++;
        end
    endtask
    task conclude;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        #(100 * 8000);
        failures++;
        conclude();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {reset_i, seed, failures, checks} = {1'b1, 32'hC323, 64'h0};
        {por_i, pin_reset_i, wdog_reset_i, emulation_i, irq_rst_sel_i} = 5'h00;
        {watchdog_disable_i, flag_clr_req_i, step_two_i, wr_i, rd_i} = 5'h00;
        {irq_i, irq_en_i, addr_i, wdata_i} = 0;
        repeat (8) @(posedge clk_i);
        #10 reset_i = 0;
        chk("pins", 0, pin_funcs_o);
        acc(0, 16'hFE00, 8'h00);
        acc(0, 16'hFE03, 8'h00);
        acc(0, 16'hFE01, 8'h80);
        acc(1, 16'hFE01, 8'hFF);
        acc(0, 16'hFE01, 8'h00);
        acc(0, 16'hFE02, 8'h00);
        {pin_reset_i, wdog_reset_i} = 2'b11;
        @(posedge clk_i);
        #10 {pin_reset_i, wdog_reset_i} = 2'b00;
        acc(0, 16'hFE01, 8'h50);
        repeat (4) begin
            d = $random(seed);
            acc(1, 16'hFE03, d[7:0]);
            acc(0, 16'hFE03, d[7:0] & 8'h80);
        end
        acc(1, 16'hFE03, 8'h00);
        repeat (20) begin
            irq_i = $random(seed);
            irq_en_i = $random(seed);
            lo = 31;
            for (int i = 23; i >= 0; i--) if (irq_i[i] && irq_en_i[i]) lo = i;
            repeat (4) @(posedge clk_i);
            #10;
            chk("pending", lo != 31, irq_pending_o);
            if (lo != 31) chk("vector", lo, irq_vec_o);
        end
        {irq_i, irq_en_i} = {24'h0, 24'hFFFFFF};
        cpu.issue(1, 0);
        chk("watchdog", 1, watchdog_run_o);
        irq_i = 24'h20;
        hunt(0, 20);
        chk("stack", 1, stack_o);
        chk("vector", 5, irq_vec_o);
        irq_i = 0;
        emulation_i = 1;
        cpu.issue(1, 3);
        cpu.issue(3, 0);
        hunt(1, 20);
        chk("cpu clock", 1, cpu_clk_en_o);
        acc(0, 16'hFE00, 8'h02);
        {flag_clr_req_i, step_two_i} = 2'b11;
        #1 chk("clear ok", 0, flag_clr_ok_o);
        acc(1, 16'hFE03, 8'h80);
        chk("clear ok", 1, flag_clr_ok_o);
        acc(1, 16'hFE03, 8'h00);
        acc(1, 16'hFE00, 8'h00);
        chk("clear ok", 1, flag_clr_ok_o);
        acc(0, 16'hFE00, 8'h00);
        cpu.issue(2, 1);
        hunt(1, 12);
        chk("stopped", 0, cpu_clk_en_o);
        irq_i = 24'h1;
        hunt(1, 80);
        chk("recovery", 1, cpu_clk_en_o === 1'b1 && hn >= 12);
        irq_i = 0;
        irq_rst_sel_i = 1;
        repeat (2) @(posedge clk_i);
        #10 irq_rst_sel_i = 0;
        repeat (2) @(posedge clk_i);
        #10 chk("pins", 1, pin_funcs_o);
        @(posedge clk_i);
        #10 reset_i = 1;
        repeat (2) @(posedge clk_i);
        #10 reset_i = 0;
        chk("pins", 0, pin_funcs_o);
        acc(0, 16'hFE01, 8'h80);
        conclude();
    end
endmodule
